// file: burst_cfg_regs.vh
// Constants for the burst read configuration block
`ifndef BURST_CFG_REGS_VH
`define BURST_CFG_REGS_VH

// ----------------------------------------------------------------
// Configuration word layout and reset value
// ----------------------------------------------------------------
`define CFG_RESET        16'hDF48
`define CFG_MODE_BIT     15
`define CFG_LAT_HI       14
`define CFG_LAT_LO       11
`define CFG_RDY_POL_BIT  10
`define CFG_RDY_TIM_BIT  8
`define CFG_DRIVE_BIT    7
`define CFG_LEN_HI       2
`define CFG_LEN_LO       0

// ----------------------------------------------------------------
// Burst length codes and group sizes
// ----------------------------------------------------------------
`define LEN_CONT         3'h0
`define LEN_WRAP8        3'h2
`define LEN_WRAP16       3'h3
`define WORDS_WRAP8      5'h08
`define WORDS_WRAP16     5'h10
`define GROUP_LAST16     4'hF
`define LAT_MIN_CODE     4'h1
`define LAT_ZERO         4'h0
// Idle pin levels {link clock, select, strobe, output enable, write strobe}
`define CTL_SYNC_IDLE    5'h0F

// ----------------------------------------------------------------
// Command codes written over the asynchronous write cycle
// ----------------------------------------------------------------
`define CMD_SET_CFG      16'h00D0
`define CMD_READ_CFG     16'h00C6
`define CMD_RESET        16'h00F0

// ----------------------------------------------------------------
// Data buffer
// ----------------------------------------------------------------
`define FIFO_DEPTH       32
`define FIFO_AW          5
`define WORD_W           16

`endif

// file: burst_cfg_core.v
// Burst read configuration word, command decode, burst engine and word buffer
// Functional notes
// - Hardware reset puts the engine idle and loads all configuration defaults.
// - Command reset returns to array mode but keeps the configuration word.
// - Configuration word is readable through the read-configuration command.
// - Bit 15 zero gives synchronous burst reads, one asynchronous; default one.
// - Writes always use asynchronous timing regardless of read mode.
// - Bits 14..11 set latency edge, code one is third edge; zero reserved.
// - Latency from 3 to 17 cycles supported, 13 after reset.
// - First word driven after edge latency minus one, captured next edge.
// - After first word, one word per clock, address advancing automatically.
// - Bit 10 sets ready polarity; one means high is valid; default one.
// - Bit 8 one gives ready with data, zero one cycle early.
// - Bit 7 zero full drive, one half drive; reset value zero.
// - Bits 2..0 choose continuous, 8-word wrap or 16-word wrap bursts.
// - Whole configuration word resets to DF48h, reserved bits included.
// - Wrapping bursts climb to group end, wrap to group start, stop.
// - Continuous bursts insert fresh latency at the first 16-word boundary and before every later word, ready off.
`include "burst_cfg_regs.vh"
`default_nettype none

// ----------------------------------------------------------------
// Word buffer
// ----------------------------------------------------------------
module word_fifo #(
  parameter WIDTH = `WORD_W,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (!rst_n || flush) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module burst_cfg_core #(
  parameter ADDR_W = 24
) (
  input  wire              clock,
  input  wire              rst_n,
  input  wire              burst_clk,
  input  wire              chip_select_n,
  input  wire              address_valid_strobe_n,
  input  wire              output_enable_n,
  input  wire              write_enable_n,
  input  wire [ADDR_W-1:0] burst_address,
  input  wire [15:0]       adq_in,
  output reg  [15:0]       adq_out,
  output reg               adq_oe,
  output reg               ready,
  output reg               half_drive,
  output reg  [15:0]       burst_config_word,
  output reg               array_req,
  output reg  [ADDR_W-1:0] array_addr,
  input  wire              array_valid,
  input  wire [15:0]       array_data
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_DONE = 2'h3;
  localparam CM_ARRAY  = 2'h0;
  localparam CM_SETCFG = 2'h1;
  localparam CM_CFGRD  = 2'h2;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [4:0]        ctl_s1_reg;
  reg [4:0]        ctl_s2_reg;
  reg [4:0]        ctl_s3_reg;
  reg [ADDR_W-1:0] addr_s1_reg;
  reg [ADDR_W-1:0] addr_s2_reg;
  reg [15:0]       dq_s1_reg;
  reg [15:0]       dq_s2_reg;

  always @(posedge clock) begin
    if (!rst_n) begin
      // Preset to idle pin levels so no false edge follows reset
      ctl_s1_reg <= `CTL_SYNC_IDLE;
      ctl_s2_reg <= `CTL_SYNC_IDLE;
      ctl_s3_reg <= `CTL_SYNC_IDLE;
    end else begin
      ctl_s1_reg <= {burst_clk, chip_select_n, address_valid_strobe_n,
                     output_enable_n, write_enable_n};
      ctl_s2_reg <= ctl_s1_reg;
      ctl_s3_reg <= ctl_s2_reg;
    end
  end

  always @(posedge clock) begin
    addr_s1_reg <= burst_address;
    addr_s2_reg <= addr_s1_reg;
    dq_s1_reg   <= adq_in;
    dq_s2_reg   <= dq_s1_reg;
  end

  wire lclk_rise = ctl_s2_reg[4] & ~ctl_s3_reg[4];
  wire ce_low    = ~ctl_s2_reg[3];
  wire avd_low   = ~ctl_s2_reg[2];
  wire oe_low    = ~ctl_s2_reg[1];
  wire we_rise   = ctl_s2_reg[0] & ~ctl_s3_reg[0];

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  reg [15:0] cfg_reg;
  reg [1:0]  cmd_reg;
  wire       async_mode = cfg_reg[`CFG_MODE_BIT];
  wire [3:0] lat_code   = cfg_reg[`CFG_LAT_HI:`CFG_LAT_LO];
  wire       rdy_pol    = cfg_reg[`CFG_RDY_POL_BIT];
  wire       rdy_early  = ~cfg_reg[`CFG_RDY_TIM_BIT];
  wire [2:0] len_code   = cfg_reg[`CFG_LEN_HI:`CFG_LEN_LO];
  // Reserved zero latency is treated as the shortest legal one
  wire [3:0] lat_load   = (lat_code == `LAT_ZERO) ? `LAT_MIN_CODE : lat_code;
  wire [4:0] wrap_words = (len_code == `LEN_WRAP8)  ? `WORDS_WRAP8 :
                          (len_code == `LEN_WRAP16) ? `WORDS_WRAP16 : 5'h00;
  wire       is_wrap    = (wrap_words != 5'h00);

  function [ADDR_W-1:0] next_addr;
    input [ADDR_W-1:0] a;
    input [2:0]        len;
    reg   [ADDR_W-1:0] inc;
    begin
      inc = a + 1'b1;
      next_addr = inc;
      if (len == `LEN_WRAP8) begin
        next_addr = {a[ADDR_W-1:3], inc[2:0]};
      end else if (len == `LEN_WRAP16) begin
        next_addr = {a[ADDR_W-1:4], inc[3:0]};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Command decode, writes sampled on write strobe release only
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_n) begin
      cfg_reg <= `CFG_RESET;
      cmd_reg <= CM_ARRAY;
    end else if (we_rise && ce_low) begin
      case (cmd_reg)
        CM_SETCFG: begin
          cfg_reg <= dq_s2_reg;
          cmd_reg <= CM_ARRAY;
        end
        default: begin
          // Command reset leaves the configuration word alone
          if (dq_s2_reg == `CMD_SET_CFG) begin
            cmd_reg <= CM_SETCFG;
          end else if (dq_s2_reg == `CMD_READ_CFG) begin
            cmd_reg <= CM_CFGRD;
          end else if (dq_s2_reg == `CMD_RESET) begin
            cmd_reg <= CM_ARRAY;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Burst engine and array fetch
  // ----------------------------------------------------------------
  reg  [1:0]        st_reg;
  reg  [3:0]        wait_reg;
  reg  [4:0]        sent_reg;
  reg  [ADDR_W-1:0] out_addr_reg;
  reg  [15:0]       word_reg;
  reg               word_ok_reg;
  reg  [4:0]        fetch_left_reg;
  reg               fetch_cont_reg;
  reg               pending_reg;
  reg               drop_reg;
  reg               avd_seen_reg;
  wire              fifo_in_ready;
  wire              fifo_out_valid;
  wire [15:0]       fifo_out_data;
  reg               fifo_pop;

  wire start_sync  = lclk_rise & ce_low & avd_low & ~oe_low & ~async_mode &
                     (cmd_reg == CM_ARRAY);
  wire start_async = avd_low & ~avd_seen_reg & ce_low & async_mode &
                     (cmd_reg == CM_ARRAY);
  wire start       = start_sync | start_async;
  wire fetch_more  = fetch_cont_reg | (fetch_left_reg != 5'h00);
  wire fetch_push  = array_valid & pending_reg & ~drop_reg;

  word_fifo #(
    .WIDTH (`WORD_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (start),
    .in_valid  (fetch_push),
    .in_ready  (fifo_in_ready),
    .in_data   (array_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // One outstanding fetch; a fetch in flight at a new start is discarded
  always @(posedge clock) begin
    if (!rst_n) begin
      array_req      <= 1'b0;
      array_addr     <= {ADDR_W{1'b0}};
      pending_reg    <= 1'b0;
      drop_reg       <= 1'b0;
      fetch_left_reg <= 5'h00;
      fetch_cont_reg <= 1'b0;
      avd_seen_reg   <= 1'b0;
    end else begin
      avd_seen_reg <= avd_low;
      if (array_valid && pending_reg) begin
        pending_reg <= 1'b0;
        array_req   <= 1'b0;
        drop_reg    <= 1'b0;
        if (!drop_reg) begin
          array_addr <= next_addr(array_addr, len_code);
        end else begin
          array_addr <= out_addr_reg;
        end
      end
      if (start) begin
        // Address held while a fetch is in flight; the dropped answer loads it
        if (!pending_reg || array_valid) begin
          array_addr <= addr_s2_reg;
        end
        fetch_cont_reg <= start_sync & ~is_wrap;
        fetch_left_reg <= start_async ? 5'h01 : wrap_words;
        if (pending_reg && !array_valid) begin
          drop_reg <= 1'b1;
        end
      end else if (!pending_reg && fetch_more && fifo_in_ready && !drop_reg) begin
        array_req   <= 1'b1;
        pending_reg <= 1'b1;
        if (!fetch_cont_reg) begin
          fetch_left_reg <= fetch_left_reg - 1'b1;
        end
      end
      if (!ce_low) begin
        fetch_cont_reg <= 1'b0;
        fetch_left_reg <= 5'h00;
      end
    end
  end

  reg  [1:0]  st_next;
  reg  [3:0]  wait_next;
  reg  [4:0]  sent_next;
  reg         emit;

  always @* begin
    st_next   = st_reg;
    wait_next = wait_reg;
    sent_next = sent_reg;
    emit      = 1'b0;
    fifo_pop  = 1'b0;
    if (start_sync) begin
      st_next   = ST_WAIT;
      wait_next = lat_load;
      sent_next = 5'h00;
    end else if (start_async) begin
      st_next = ST_DONE;
    end else if (!ce_low) begin
      st_next = ST_IDLE;
    end else if (lclk_rise) begin
      case (st_reg)
        ST_WAIT: begin
          if (wait_reg > 4'h1) begin
            wait_next = wait_reg - 1'b1;
          end else if (fifo_out_valid) begin
            emit      = 1'b1;
            fifo_pop  = 1'b1;
            st_next   = ST_DATA;
            sent_next = 5'h01;
          end
        end
        ST_DATA: begin
          if (is_wrap && sent_reg == wrap_words) begin
            st_next = ST_DONE;
          end else if (!is_wrap && out_addr_reg[3:0] == `GROUP_LAST16) begin
            st_next   = ST_WAIT;
            wait_next = lat_load;
          end else if (fifo_out_valid) begin
            emit      = 1'b1;
            fifo_pop  = 1'b1;
            sent_next = sent_reg + 1'b1;
          end
        end
        default: begin
          st_next = st_reg;
        end
      endcase
    end
  end

  // Early ready looks one edge ahead; an empty buffer there can still stall
  wire act_now   = word_ok_reg;
  wire act_early = ((st_next == ST_WAIT) && (wait_next == 4'h1) && fifo_out_valid) ||
                   ((st_next == ST_DATA) && !(is_wrap && sent_next == wrap_words) &&
                    !(!is_wrap && out_addr_reg[3:0] == `GROUP_LAST16 && !emit));
  wire act_sel   = rdy_early ? act_early : act_now;

  always @(posedge clock) begin
    if (!rst_n) begin
      st_reg       <= ST_IDLE;
      wait_reg     <= 4'h0;
      sent_reg     <= 5'h00;
      out_addr_reg <= {ADDR_W{1'b0}};
      word_reg     <= 16'h0000;
      word_ok_reg  <= 1'b0;
    end else begin
      st_reg   <= st_next;
      wait_reg <= wait_next;
      sent_reg <= sent_next;
      if (start) begin
        out_addr_reg <= addr_s2_reg;
        word_ok_reg  <= 1'b0;
      end else if (emit) begin
        word_reg    <= fifo_out_data;
        word_ok_reg <= 1'b1;
        if (st_reg == ST_DATA) begin
          out_addr_reg <= next_addr(out_addr_reg, len_code);
        end
      end else if (lclk_rise && st_reg != ST_DONE) begin
        word_ok_reg <= 1'b0;
      end else if (!ce_low) begin
        word_ok_reg <= 1'b0;
      end else if (st_reg == ST_DONE && async_mode && fifo_out_valid && !word_ok_reg) begin
        word_reg    <= fifo_out_data;
        word_ok_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_n) begin
      adq_out           <= 16'h0000;
      adq_oe            <= 1'b0;
      ready             <= 1'b0;
      half_drive        <= 1'b0;
      burst_config_word <= `CFG_RESET;
    end else begin
      half_drive        <= cfg_reg[`CFG_DRIVE_BIT];
      burst_config_word <= cfg_reg;
      adq_oe            <= ce_low & oe_low & ~avd_low;
      if (cmd_reg == CM_CFGRD) begin
        adq_out <= cfg_reg;
        ready   <= rdy_pol;
      end else begin
        adq_out <= word_reg;
        ready   <= rdy_pol ? act_sel : ~act_sel;
      end
    end
  end
endmodule
`default_nettype wire

// file: burst_cfg_core_pad.v
// Intentionally empty companion file
`default_nettype none
`default_nettype wire

// file: burst_cfg_core_asserts.sv
// Concurrent checks on the ports of the burst configuration block
`default_nettype none
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module burst_cfg_core_asserts #(
  parameter int ADDR_W = 24
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              chip_select_n,
  input wire logic              address_valid_strobe_n,
  input wire logic              output_enable_n,
  input wire logic              write_enable_n,
  input wire logic              adq_oe,
  input wire logic              ready,
  input wire logic              half_drive,
  input wire logic [15:0]       burst_config_word,
  input wire logic              array_req,
  input wire logic [ADDR_W-1:0] array_addr,
  input wire logic              array_valid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_RST_DEFAULTS: assert property (
    $rose(rst_n) |-> burst_config_word == 16'hDF48 && !half_drive && !adq_oe && !array_req)
    else $error("reset defaults wrong");
  AST_HALF_DRIVE: assert property (
    $stable(burst_config_word) [*3] |-> half_drive == burst_config_word[7])
    else $error("drive strength does not follow config");
  AST_CFG_HOLD: assert property (
    write_enable_n [*8] |-> $stable(burst_config_word))
    else $error("config changed without a write");
  AST_OE_OFF_OEN: assert property (
    output_enable_n [*5] |-> !adq_oe)
    else $error("bus driven with output enable off");
  AST_OE_OFF_CE: assert property (
    chip_select_n [*5] |-> !adq_oe)
    else $error("bus driven while deselected");
  AST_OE_OFF_STROBE: assert property (
    !address_valid_strobe_n [*5] |-> !adq_oe)
    else $error("bus driven during address strobe");
  AST_REQ_HOLD: assert property (
    array_req && !array_valid |=> array_req && $stable(array_addr))
    else $error("fetch request dropped early");
  AST_RDY_CAPTURE: assert property (
    !address_valid_strobe_n [*6] ##0 $stable(burst_config_word)
      |-> ready == !burst_config_word[10])
    else $error("ready not idle during capture");
endmodule

bind burst_cfg_core burst_cfg_core_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .clock(clock), .rst_n(rst_n), .chip_select_n(chip_select_n),
  .address_valid_strobe_n(address_valid_strobe_n), .output_enable_n(output_enable_n),
  .write_enable_n(write_enable_n), .adq_oe(adq_oe), .ready(ready),
  .half_drive(half_drive), .burst_config_word(burst_config_word),
  .array_req(array_req), .array_addr(array_addr), .array_valid(array_valid)
);
`default_nettype wire

// file: host_bus_model.sv
// Host memory controller model driving the burst bus pins
`default_nettype none
// ----------------------------------------------------------------
// Host model
// ----------------------------------------------------------------
module host_bus_model #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clock,
  input  wire logic [15:0]       adq_out,
  input  wire logic              adq_oe,
  input  wire logic              ready,
  output var  logic              burst_clk,
  output var  logic              chip_select_n,
  output var  logic              address_valid_strobe_n,
  output var  logic              output_enable_n,
  output var  logic              write_enable_n,
  output var  logic [ADDR_W-1:0] burst_address,
  output var  logic [15:0]       adq_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] wd [0:15];
  int          wr [0:15];
  int          first_rise;
  int          n_got;
  logic        last_ok;

  initial begin
    burst_clk = 1'b0;
    chip_select_n = 1'b1;
    address_valid_strobe_n = 1'b1;
    output_enable_n = 1'b1;
    write_enable_n = 1'b1;
    burst_address = '0;
    adq_in = 16'h0000;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Plain strobed write; the burst clock stays still
  task automatic write_word(input logic [15:0] w);
    @(posedge clock);
    chip_select_n <= 1'b0;
    write_enable_n <= 1'b0;
    adq_in <= w;
    idle(4);
    write_enable_n <= 1'b1;
    idle(4);
    chip_select_n <= 1'b1;
    adq_in <= ~w;
    idle(6);
  endtask

  // Only validated latency and length codes are handed in
  task automatic set_cfg(input logic [15:0] v);
    write_word(16'h00D0);
    write_word(v);
  endtask

  // Released data lines show the inverse, never the last word
  task automatic read_cfg(output logic [15:0] v);
    write_word(16'h00C6);
    chip_select_n <= 1'b0;
    output_enable_n <= 1'b0;
    idle(8);
    v = adq_oe ? adq_out : ~adq_out;
    chip_select_n <= 1'b1;
    output_enable_n <= 1'b1;
    write_word(16'h00F0);
  endtask

  task automatic async_read(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    @(posedge clock);
    chip_select_n <= 1'b0;
    burst_address <= a;
    address_valid_strobe_n <= 1'b0;
    idle(2);
    address_valid_strobe_n <= 1'b1;
    output_enable_n <= 1'b0;
    burst_address <= ~a;
    idle(12);
    v = adq_oe ? adq_out : ~adq_out;
    chip_select_n <= 1'b1;
    output_enable_n <= 1'b1;
    idle(4);
  endtask

  // Words are taken at burst clock rises; the clock runs only inside the frame
  task automatic burst(input logic [ADDR_W-1:0] a, input int n, input logic pol,
                       input logic early);
    logic ok;
    logic prev;
    logic vld;
    n_got = 0;
    first_rise = 0;
    last_ok = 1'b0;
    prev = 1'b0;
    @(posedge clock);
    chip_select_n <= 1'b0;
    burst_address <= a;
    address_valid_strobe_n <= 1'b0;
    output_enable_n <= 1'b1;
    for (int k = 1; k <= 40; k++) begin
      #62.5 burst_clk = 1'b1;
      ok = (ready === pol);
      if (ok && first_rise == 0) first_rise = k;
      vld = early ? prev : ok;
      if (k > 1 && vld && n_got < n) begin
        wd[n_got] = adq_oe ? adq_out : ~adq_out;
        wr[n_got] = k;
        n_got++;
      end else if (k > 1 && vld) begin
        last_ok = 1'b1;
      end
      prev = ok;
      #62.5 burst_clk = 1'b0;
      address_valid_strobe_n <= 1'b1;
      output_enable_n <= 1'b0;
      burst_address <= ~a;
    end
    chip_select_n <= 1'b1;
    output_enable_n <= 1'b1;
    idle(4);
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the burst configuration block
`default_nettype none
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [15:0] cfg;
    logic [23:0] addr;
    logic [4:0]  n;
    logic [4:0]  lat;
  } row_t;
  // Latency 3, 7 (early ready), 13 and 14; wrap16, wrap8, continuous, wrap8
  localparam row_t rows [0:3] = '{
    '{16'h0F4B, 24'h00001E, 5'h10, 5'h03},
    '{16'h2E4A, 24'h000013, 5'h08, 5'h07},
    '{16'h5F48, 24'h00000E, 5'h03, 5'h0D},
    '{16'h63CA, 24'h000005, 5'h08, 5'h0E}};
  logic        clock, rst_n, burst_clk, chip_select_n, address_valid_strobe_n;
  logic        output_enable_n, write_enable_n, adq_oe, ready, half_drive;
  logic        array_req, array_valid;
  logic [23:0] burst_address, array_addr;
  logic [15:0] adq_in, adq_out, burst_config_word, array_data, v;
  int          n_mismatch, tests_run;
  row_t        r;

  burst_cfg_core #(.ADDR_W(24)) u_dut (
    .clock(clock), .rst_n(rst_n), .burst_clk(burst_clk), .chip_select_n(chip_select_n),
    .address_valid_strobe_n(address_valid_strobe_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .burst_address(burst_address), .adq_in(adq_in),
    .adq_out(adq_out), .adq_oe(adq_oe), .ready(ready), .half_drive(half_drive),
    .burst_config_word(burst_config_word), .array_req(array_req),
    .array_addr(array_addr), .array_valid(array_valid), .array_data(array_data));
  host_bus_model #(.ADDR_W(24)) u_host (
    .clock(clock), .adq_out(adq_out), .adq_oe(adq_oe), .ready(ready),
    .burst_clk(burst_clk), .chip_select_n(chip_select_n),
    .address_valid_strobe_n(address_valid_strobe_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .burst_address(burst_address), .adq_in(adq_in));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Array answers one clock after each new request
  always @(posedge clock) begin
    array_valid <= rst_n && array_req && !array_valid;
    array_data <= array_addr[15:0] ^ 16'h3C00;
  end

  function automatic logic [23:0] exp_addr(input logic [23:0] a, input logic [2:0] len,
                                           input int i);
    logic [23:0] m;
    m = (len == 3'h3) ? 24'h00000F : (len == 3'h2) ? 24'h000007 : 24'hFFFFFF;
    return (a & ~m) | ((a + 24'(i)) & m);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is about 23 us; nearly nine times that is a hang
  initial begin
    #200us;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end

  initial begin
    rst_n = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check(burst_config_word, 16'hDF48, "reset word");
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      u_host.set_cfg(r.cfg);
      #1;
      check(burst_config_word, r.cfg, "config word");
      check({15'h0000, half_drive}, {15'h0000, r.cfg[7]}, "drive");
      u_host.burst(r.addr, int'(r.n), r.cfg[10], !r.cfg[8]);
      check(16'(u_host.first_rise), 16'(r.lat) - 16'(!r.cfg[8]), "ready start");
      check(16'(u_host.n_got), 16'(r.n), "word count");
      for (int j = 0; j < int'(r.n); j++) begin
        check(u_host.wd[j], 16'(exp_addr(r.addr, r.cfg[2:0], j)) ^ 16'h3C00, "word");
        if (r.cfg[2:0] != 3'h0)
          check(16'(u_host.wr[j]), 16'(r.lat) + 16'(j), "word rise");
      end
      if (r.cfg[2:0] != 3'h0)
        check({15'h0000, u_host.last_ok}, 16'h0000, "wrap end");
      else
        check(16'((u_host.wr[2] - u_host.wr[1]) > 1), 16'h0001, "line wait");
      $display("burst row %0d done", i);
    end
    u_host.read_cfg(v);
    check(v, 16'h63CA, "read back");
    u_host.read_cfg(v);
    check(v, 16'h63CA, "after command reset");
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    check(burst_config_word, 16'hDF48, "second reset word");
    check({15'h0000, half_drive}, 16'h0000, "reset drive");
    u_host.read_cfg(v);
    check(v, 16'hDF48, "reset read back");
    u_host.async_read(24'h000123, v);
    check(v, 16'h3D23, "async read");
    $display("reset and readback tests done");
    results();
  end
endmodule
`default_nettype wire
